// [rtl/switch_input_current_config.sv]
// Purpose: Configuration and current control for 22 switch inputs, written over a 24-bit serial link.
// Assumes: Comparator outputs and the normal-mode level arrive from outside the clock domain.
// Notes:   Inputs 0..13 are ground inputs, 14..21 programmable inputs; analog select overrides.
`timescale 1ns/1ns
module switch_input_current_config #(
  parameter int unsigned WET_COUNT = switch_cfg_pkg::WET_CYCLES
) (
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  input  wire logic                                      sclk_i,
  input  wire logic                                      cs_n_i,
  input  wire logic                                      sdi_i,
  output logic                                           sdo_o,
  input  wire logic                                      normal_mode_i,
  input  wire logic [switch_cfg_pkg::NUM_INPUTS-1:0]     comp_i,
  output switch_cfg_pkg::drive_type [switch_cfg_pkg::NUM_INPUTS-1:0] drive_o,
  output logic                                           monitor_enable_o,
  output logic [switch_cfg_pkg::NUM_INPUTS-1:0]          monitor_select_o,
  output logic [switch_cfg_pkg::NUM_INPUTS-1:0]          contact_current_level_o,
  output logic [switch_cfg_pkg::NUM_INPUTS-1:0]          wetting_timer_enable_o,
  output logic [switch_cfg_pkg::NUM_INPUTS-1:0]          input_high_impedance_o,
  output logic [6:0]                                     analog_channel_select_o
);
  import switch_cfg_pkg::*;

  typedef struct packed {
    logic [NUM_INPUTS-1:0] comp_s1;
    logic [NUM_INPUTS-1:0] comp_s2;
    logic [1:0]            mode_s;
    logic [NUM_INPUTS-1:0] level;
    logic [NUM_INPUTS-1:0] timer_en;
    logic [NUM_INPUTS-1:0] hiz;
    logic [6:0]            analog;
    logic [NUM_INPUTS-1:0] sel_mask;
    drive_type [NUM_INPUTS-1:0] drive;
  } cfg_state_type;

  cfg_state_type st_q;
  cfg_state_type st_d;

  logic                  frame_valid;
  logic [FRAME_BITS-1:0] frame;
  logic [FRAME_BITS-1:0] status_word;
  logic [NUM_INPUTS-1:0] expired;
  logic [NUM_INPUTS-1:0] closed_masked;

  // Serial link receiver; status is loaded at chip select fall.
  serial_frame_rx u_rx (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .sclk_i        (sclk_i),
    .cs_n_i        (cs_n_i),
    .sdi_i         (sdi_i),
    .status_i      (status_word),
    .sdo_o         (sdo_o),
    .frame_valid_o (frame_valid),
    .frame_o       (frame)
  );

  // One independent timer per input, fed from the synchronised comparator.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_timer
      wetting_timer #(
        .WET_COUNT (WET_COUNT)
      ) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .comp_i    (st_q.comp_s2[gi]),
        .enable_i  (st_q.timer_en[gi]),
        .expired_o (expired[gi])
      );
    end
  endgenerate

  // Comparator state stays valid under tri-state; the analog channel reads zero.
  assign closed_masked = st_q.comp_s2 & ~st_q.sel_mask;
  assign status_word   = {2'b00, closed_masked[NUM_INPUTS-1:NUM_GROUND], closed_masked[NUM_GROUND-1:0]};

  // Register updates, analog decode and per-input drive selection.
  always_comb begin
    logic [NUM_INPUTS-1:0] mask;
    logic [1:0]            cur;
    logic                  wr;
    mask = '0;
    cur  = 2'h0;
    wr   = 1'b0;
    st_d = st_q;
    st_d.comp_s1 = comp_i;
    st_d.comp_s2 = st_q.comp_s1;
    st_d.mode_s  = {st_q.mode_s[0], normal_mode_i};
    wr = frame_valid & st_q.mode_s[1];
    if (wr) begin
      case (frame[CMD_MSB:CMD_LSB])
        CMD_LEVEL_PROG: st_d.level[NUM_INPUTS-1:NUM_GROUND] = frame[NUM_PROG-1:0];
        CMD_LEVEL_GND:  st_d.level[NUM_GROUND-1:0]          = frame[NUM_GROUND-1:0];
        CMD_TIMER_PROG: st_d.timer_en[NUM_INPUTS-1:NUM_GROUND] = frame[NUM_PROG-1:0];
        CMD_TIMER_GND:  st_d.timer_en[NUM_GROUND-1:0]          = frame[NUM_GROUND-1:0];
        CMD_HIZ_PROG:   st_d.hiz[NUM_INPUTS-1:NUM_GROUND] = frame[NUM_PROG-1:0];
        CMD_HIZ_GND:    st_d.hiz[NUM_GROUND-1:0]          = frame[NUM_GROUND-1:0];
        CMD_ANALOG:     st_d.analog = frame[ANA_CUR_MSB:ANA_CH_LSB];
        CMD_RESET: begin
          st_d.level    = LEVEL_RESET;
          st_d.timer_en = TIMER_RESET;
          st_d.hiz      = HIZ_RESET;
          st_d.analog   = ANALOG_RESET;
        end
        default: begin
        end
      endcase
    end
    // One-hot select from the channel code; codes above the last select nothing.
    for (int i = 0; i < NUM_INPUTS; i++) begin
      mask[i] = (st_q.analog[ANA_CH_MSB:ANA_CH_LSB] == 5'(i + 1));
    end
    st_d.sel_mask = mask;
    cur = st_q.analog[ANA_CUR_MSB:ANA_CUR_LSB];
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (st_q.sel_mask[i]) begin
        // Analog currents are pull-up only; the unused 11 code acts as high impedance.
        case (cur)
          ANA_CUR_LOW:  st_d.drive[i] = DRIVE_LOW;
          ANA_CUR_HIGH: st_d.drive[i] = DRIVE_HIGH;
          default:      st_d.drive[i] = DRIVE_OFF;
        endcase
      end else if (st_q.hiz[i]) begin
        st_d.drive[i] = DRIVE_OFF;
      end else if (st_q.level[i] && !(st_q.timer_en[i] && expired[i])) begin
        st_d.drive[i] = DRIVE_HIGH;
      end else begin
        st_d.drive[i] = DRIVE_LOW;
      end
    end
  end

  // State register with power-on defaults.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q          <= '0;
      st_q.level    <= LEVEL_RESET;
      st_q.timer_en <= TIMER_RESET;
      st_q.hiz      <= HIZ_RESET;
      st_q.analog   <= ANALOG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign drive_o                 = st_q.drive;
  assign monitor_select_o        = st_q.sel_mask;
  assign monitor_enable_o        = |st_q.sel_mask;
  assign contact_current_level_o = st_q.level;
  assign wetting_timer_enable_o  = st_q.timer_en;
  assign input_high_impedance_o  = st_q.hiz;
  assign analog_channel_select_o = st_q.analog;

  // A written level frame lands in the register one cycle later.
  sequence level_gnd_write_s;
    frame_valid && st_q.mode_s[1] && frame[CMD_MSB:CMD_LSB] == CMD_LEVEL_GND;
  endsequence
  level_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    level_gnd_write_s |=> st_q.level[NUM_GROUND-1:0] == $past(frame[NUM_GROUND-1:0]))
    else $error("ground level write lost");

  // Outside normal mode no frame changes the configuration.
  no_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_valid && !st_q.mode_s[1]) |=> $stable(st_q.level) && $stable(st_q.hiz) && $stable(st_q.analog))
    else $error("write accepted outside normal mode");

  // Reset command restores defaults.
  reset_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_valid && st_q.mode_s[1] && frame[CMD_MSB:CMD_LSB] == CMD_RESET) |=>
      st_q.hiz == HIZ_RESET && st_q.analog == ANALOG_RESET && st_q.timer_en == TIMER_RESET)
    else $error("reset command did not restore defaults");

  // At most one input is routed to the monitor.
  one_channel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(st_q.sel_mask)) else $error("more than one analog channel");

  // The selected analog input reports zero in status.
  status_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_word[NUM_INPUTS-1:0] & st_q.sel_mask) == '0) else $error("analog channel not masked");

  // A tri-stated input that is not the analog channel drives nothing after two cycles.
  hiz_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q.hiz[0] && !st_q.sel_mask[0]) [*2] |-> drive_o[0] == DRIVE_OFF)
    else $error("tri-stated input driven");

  // The forbidden 11 code never yields current on the selected input.
  forbidden_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q.analog[ANA_CUR_MSB:ANA_CUR_LSB] == 2'h3 && $stable(st_q.analog)) |=>
      drive_o[NUM_INPUTS-1] == DRIVE_OFF || !st_q.sel_mask[NUM_INPUTS-1])
    else $error("forbidden analog current code drove input");

  // An active high-level input with its timer disabled keeps the high current.
  timer_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_q.hiz[2] && st_q.level[2] && !st_q.timer_en[2] && !st_q.sel_mask[2]) |=> drive_o[2] == DRIVE_HIGH)
    else $error("high current dropped with timer disabled");

endmodule

// [shared/switch_cfg_pkg.sv]
// Purpose: Shared constants and types for the switch input current configuration block.
// Assumes: 22 inputs, 14 ground inputs at low indices, 8 programmable inputs above them.
// Notes:   Input index i < 14 is ground input i; index 14 + n is programmable input n.
package switch_cfg_pkg;

  localparam int unsigned NUM_INPUTS = 22;
  localparam int unsigned NUM_GROUND = 14;
  localparam int unsigned NUM_PROG   = 8;
  localparam int unsigned FRAME_BITS = 24;

  // Command codes carried in frame bits 23..16.
  localparam logic [7:0] CMD_LEVEL_PROG  = 8'h04;
  localparam logic [7:0] CMD_LEVEL_GND   = 8'h05;
  localparam logic [7:0] CMD_ANALOG      = 8'h06;
  localparam logic [7:0] CMD_TIMER_PROG  = 8'h07;
  localparam logic [7:0] CMD_TIMER_GND   = 8'h08;
  localparam logic [7:0] CMD_HIZ_PROG    = 8'h09;
  localparam logic [7:0] CMD_HIZ_GND     = 8'h0a;
  localparam logic [7:0] CMD_RESET       = 8'h7f;

  // Frame field positions.
  localparam int unsigned CMD_MSB        = 23;
  localparam int unsigned CMD_LSB        = 16;
  localparam int unsigned ANA_CUR_MSB    = 6;
  localparam int unsigned ANA_CUR_LSB    = 5;
  localparam int unsigned ANA_CH_MSB     = 4;
  localparam int unsigned ANA_CH_LSB     = 0;

  // Analog channel codes: 1..14 ground inputs, 15..22 programmable inputs.
  localparam logic [4:0] ANA_CH_NONE     = 5'h00;
  localparam logic [4:0] ANA_CH_LAST     = 5'h16;

  // Analog current select encodings.
  localparam logic [1:0] ANA_CUR_HIZ     = 2'h0;
  localparam logic [1:0] ANA_CUR_LOW     = 2'h1;
  localparam logic [1:0] ANA_CUR_HIGH    = 2'h2;

  // Reset values.
  localparam logic [21:0] LEVEL_RESET    = 22'h3fffff;
  localparam logic [21:0] TIMER_RESET    = 22'h3fffff;
  localparam logic [21:0] HIZ_RESET      = 22'h3fffff;
  localparam logic [6:0]  ANALOG_RESET   = 7'h00;

  // Wetting time base.
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned WET_TIME_MS    = 20;
  localparam int unsigned WET_CYCLES     = CLK_HZ / 1000 * WET_TIME_MS;
  localparam int unsigned WET_CNT_W      = 22;

  // Contact current drive per input.
  typedef enum logic [1:0] {
    DRIVE_OFF  = 2'b00,
    DRIVE_LOW  = 2'b01,
    DRIVE_HIGH = 2'b10
  } drive_type;

endpackage

// [rtl/serial_frame_rx.sv]
// Purpose: Synchronises the serial pins and collects one 24-bit frame per chip select low period.
// Assumes: Mode 0 style link: data sampled on rising link clock, shifted out on falling edge.
// Notes:   A frame with other than 24 clocks is dropped without any flag and is not delivered.
`timescale 1ns/1ns
module serial_frame_rx (
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  input  wire logic                                      sclk_i,
  input  wire logic                                      cs_n_i,
  input  wire logic                                      sdi_i,
  input  wire logic [switch_cfg_pkg::FRAME_BITS-1:0]     status_i,
  output logic                                           sdo_o,
  output logic                                           frame_valid_o,
  output logic [switch_cfg_pkg::FRAME_BITS-1:0]          frame_o
);
  import switch_cfg_pkg::*;

  typedef struct packed {
    logic [2:0]            sclk_s;
    logic [2:0]            cs_s;
    logic [1:0]            sdi_s;
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] out_sr;
    logic [4:0]            count;
    logic                  sdo;
    logic                  valid;
    logic [FRAME_BITS-1:0] frame;
  } rx_state_type;

  rx_state_type st_q;
  rx_state_type st_d;

  // Two-flop synchronisers; link clock and chip select also feed a third stage used only for edge detection.
  always_comb begin
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    rise    = 1'b0;
    fall    = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    st_d = st_q;
    st_d.sclk_s = {st_q.sclk_s[1:0], sclk_i};
    st_d.cs_s   = {st_q.cs_s[1:0], cs_n_i};
    st_d.sdi_s  = {st_q.sdi_s[0], sdi_i};
    rise    = st_q.sclk_s[1] & ~st_q.sclk_s[2];
    fall    = ~st_q.sclk_s[1] & st_q.sclk_s[2];
    cs_fall = ~st_q.cs_s[1] & st_q.cs_s[2];
    cs_rise = st_q.cs_s[1] & ~st_q.cs_s[2];
    st_d.valid = 1'b0;
    if (cs_fall) begin
      st_d.count  = 5'h00;
      st_d.out_sr = status_i;
      st_d.sdo    = status_i[FRAME_BITS-1];
    end else if (!st_q.cs_s[1]) begin
      if (rise) begin
        st_d.shift = {st_q.shift[FRAME_BITS-2:0], st_q.sdi_s[1]};
        if (st_q.count != 5'h1f) begin
          st_d.count = st_q.count + 5'h01;
        end
      end
      if (fall) begin
        st_d.out_sr = {st_q.out_sr[FRAME_BITS-2:0], 1'b0};
        st_d.sdo    = st_q.out_sr[FRAME_BITS-2];
      end
    end else if (cs_rise && st_q.count == 5'(FRAME_BITS)) begin
      st_d.valid = 1'b1;
      st_d.frame = st_q.shift;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.sclk_s <= 3'h0;
      st_q.cs_s   <= 3'h7;
    end else begin
      st_q <= st_d;
    end
  end

  assign sdo_o         = st_q.sdo;
  assign frame_valid_o = st_q.valid;
  assign frame_o       = st_q.frame;

  // A delivered frame always carries exactly 24 captured clocks.
  frame_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.valid |-> $past(st_q.count) == 5'(FRAME_BITS)) else $error("frame delivered with wrong length");

endmodule

// [rtl/wetting_timer.sv]
// Purpose: One 20 ms wetting timer for a single switch input.
// Assumes: Comparator level is already synchronised to clk_i.
// Notes:   Expired stays high until the comparator changes again or timing is disabled.
`timescale 1ns/1ns
module wetting_timer #(
  parameter int unsigned WET_COUNT = switch_cfg_pkg::WET_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic comp_i,
  input  wire logic enable_i,
  output logic      expired_o
);
  import switch_cfg_pkg::*;

  typedef struct packed {
    logic                 comp;
    logic [WET_CNT_W-1:0] count;
    logic                 expired;
  } timer_state_type;

  timer_state_type st_q;
  timer_state_type st_d;

  // Restart on every comparator change; count while enabled.
  always_comb begin
    st_d = st_q;
    st_d.comp = comp_i;
    if (comp_i != st_q.comp || !enable_i) begin
      st_d.count   = '0;
      st_d.expired = 1'b0;
    end else if (!st_q.expired) begin
      if (st_q.count == WET_CNT_W'(WET_COUNT - 1)) begin
        st_d.expired = 1'b1;
      end else begin
        st_d.count = st_q.count + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired_o = st_q.expired;

  // A comparator change clears the expiry on the next cycle.
  timer_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (comp_i != st_q.comp) |=> !expired_o) else $error("timer not restarted on comparator change");

  // A disabled timer never reports expiry.
  timer_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !expired_o) else $error("disabled timer expired");

endmodule

// [bench/spi_host_model.sv]
// Purpose: Host side of the 24-bit serial link that programs the switch block.
// Assumes: Link clock idles low; data set while it is low, taken on its rise.
// Notes:   half sets the link half period in clk cycles; a larger value gives a slow host.
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  int half = 10;

  // Idle levels: deselected, link clock still.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  task automatic wait_half();
    repeat (half) @(posedge clk_i);
  endtask

  // One exchange, MSB first; status is shifted in while the command goes out.
  // Fewer than 24 bits gives a truncated frame on purpose.
  task automatic xfer(input logic [23:0] cmd, input int nbits, output logic [23:0] st);
    st = '0;
    cs_n_o <= 1'b0;
    wait_half();
    for (int i = 23; i > 23 - nbits; i--) begin
      sdi_o <= cmd[i];
      wait_half();
      sclk_o <= 1'b1;
      st[i] = sdo_i;
      wait_half();
      sclk_o <= 1'b0;
    end
    wait_half();
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o; // Released line shows no stale level.
    wait_half();
  endtask
endmodule

// [bench/tb.sv]
// Purpose: Self-checking bench for the switch input current configuration block.
// Assumes: Short wetting count of 50 cycles; link clock of 160 ns from the host model, 320 ns for the final reset write.
// Notes:   Expected values come from the command layout and the package constants.
`timescale 1ns/1ns
module tb;
  import switch_cfg_pkg::*;
  localparam int WET = 50;
  logic                       clk, rst, sclk, cs_n, sdi, sdo, normal_mode, mon_en;
  logic [NUM_INPUTS-1:0]      comp, mon_sel, level, timer_en, hiz, one;
  logic [6:0]                 ana;
  logic [23:0]                st;
  drive_type [NUM_INPUTS-1:0] drive;
  int                         mismatches = 0;
  int                         cmp_count = 0;
  int                         idx;
  logic [4:0]                 ch_tab [4] = '{5'h01, 5'h0e, 5'h0f, 5'h16};
  logic [1:0]                 cur_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  drive_type                  drv_tab [4] = '{DRIVE_OFF, DRIVE_LOW, DRIVE_HIGH, DRIVE_OFF};

  switch_input_current_config #(.WET_COUNT(WET)) dut (
    .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
    .normal_mode_i(normal_mode), .comp_i(comp), .drive_o(drive), .monitor_enable_o(mon_en),
    .monitor_select_o(mon_sel), .contact_current_level_o(level), .wetting_timer_enable_o(timer_en),
    .input_high_impedance_o(hiz), .analog_channel_select_o(ana));

  spi_host_model host (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    host.xfer({code, data}, 24, st);
  endtask

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence of writes and checks.
  initial begin
    rst = 1'b1;
    normal_mode = 1'b1;
    comp = '0;
    cycles(2);
    rst <= 1'b0;
    cycles(4);
    chk(level, LEVEL_RESET);
    chk(timer_en, TIMER_RESET);
    chk(hiz, HIZ_RESET);
    chk(ana, ANALOG_RESET);
    chk(drive, '0);
    wr(CMD_LEVEL_PROG, 16'hffa5);
    wr(CMD_LEVEL_GND, 16'heb3c);
    chk(level, {8'ha5, 14'h2b3c});
    wr(CMD_TIMER_PROG, 16'h005a);
    wr(CMD_TIMER_GND, 16'hc003);
    chk(timer_en, {8'h5a, 14'h0003});
    wr(CMD_HIZ_PROG, 16'h0000);
    wr(CMD_HIZ_GND, 16'h0000);
    chk(hiz, '0);
    chk(drive[0], DRIVE_LOW);
    chk(drive[2], DRIVE_HIGH);
    // Two enabled timers started 30 cycles apart must expire separately.
    wr(CMD_LEVEL_GND, 16'h3fff);
    comp <= comp ^ 22'h1;
    cycles(30);
    comp <= comp ^ 22'h2;
    cycles(8);
    chk(drive[1:0], {DRIVE_HIGH, DRIVE_HIGH});
    cycles(30);
    chk(drive[1:0], {DRIVE_HIGH, DRIVE_LOW});
    cycles(30);
    chk(drive[1], DRIVE_LOW);
    chk(drive[2], DRIVE_HIGH);
    wr(CMD_HIZ_GND, 16'h0001);
    chk(drive[0], DRIVE_OFF);
    host.xfer(24'h000000, 24, st);
    chk(st, 24'h000003);
    // Each current code on a different channel, status checked in the next frame.
    comp <= '1;
    for (int k = 0; k < 4; k++) begin
      wr(CMD_ANALOG, {9'h000, cur_tab[k], ch_tab[k]});
      idx = ch_tab[k] - 5'h01;
      one = 22'h1 << idx;
      chk(mon_sel, one);
      chk(mon_en, 1'b1);
      chk(ana, {cur_tab[k], ch_tab[k]});
      chk(drive[idx], drv_tab[k]);
      host.xfer(24'h000000, 24, st);
      chk(st, {2'b00, ~one});
    end
    chk(drive[21], DRIVE_OFF);
    wr(CMD_ANALOG, 16'h0040);
    chk(mon_en, 1'b0);
    chk(mon_sel, '0);
    chk(drive[0], DRIVE_OFF);
    // Refused writes leave the registers alone.
    normal_mode <= 1'b0;
    cycles(4);
    wr(CMD_HIZ_GND, 16'h3fff);
    chk(hiz, 22'h000001);
    normal_mode <= 1'b1;
    cycles(4);
    host.xfer({CMD_HIZ_GND, 16'h3fff}, 23, st);
    chk(hiz, 22'h000001);
    host.half = 20;
    wr(CMD_RESET, 16'h0000);
    chk(level, LEVEL_RESET);
    chk(timer_en, TIMER_RESET);
    chk(hiz, HIZ_RESET);
    chk(ana, ANALOG_RESET);
    final_report();
  end

  // Watchdog against a hung handshake.
  initial begin
    cycles(100000);
    mismatches++;
    final_report();
  end
endmodule
